// [common/ohf_if.sv]
// Pin-level link between the host and the display front end.
// Bus resolves from the two enables; undriven lines read low as if pulled down.
`timescale 1ns/1ps
interface ohf_if;
  logic cs_n;
  logic dc;
  logic hard_reset_n;
  logic strap_a;
  logic strap_b;
  logic e_rd;
  logic rw_wr;
  logic [7:0] host_bus_out;
  logic [7:0] host_bus_oe;
  logic [7:0] dev_bus_out;
  logic dev_bus_oe;
  logic [7:0] host_data_bus;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      host_data_bus[i] = host_bus_oe[i] ? host_bus_out[i] : (dev_bus_oe & dev_bus_out[i]);
    end
  end

  modport host (
    output cs_n, dc, hard_reset_n, strap_a, strap_b, e_rd, rw_wr, host_bus_out, host_bus_oe,
    input host_data_bus
  );
  modport dev (
    input cs_n, dc, hard_reset_n, strap_a, strap_b, e_rd, rw_wr, host_data_bus,
    output dev_bus_out, dev_bus_oe
  );
endinterface

// [common/ohf_pkg.sv]
// Shared constants, types and helpers for the display host interface front end.
// Assumes a 40 MHz system clock on both ends and a host-made serial clock.
package ohf_pkg;

  typedef enum logic [1:0] {
    OHF_MODE_SERIAL, OHF_MODE_ESTROBE, OHF_MODE_SSTROBE, OHF_MODE_NONE
  } ohf_mode_t;

  // Host pins as seen by the device, synchronised as one word
  typedef struct packed {
    logic hard_reset_n;
    logic strap_b;
    logic strap_a;
    logic dc;
    logic rw_wr;
    logic e_rd;
    logic cs_n;
    logic [7:0] bus;
  } ohf_pins_t;

  localparam logic [7:0] OHF_CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] OHF_CMD_DISP_ON = 8'haf;
  localparam logic [7:0] OHF_CMD_REMAP = 8'ha0;
  localparam logic [7:0] OHF_CMD_START = 8'ha1;
  localparam logic [7:0] OHF_CMD_MUX = 8'hca;
  localparam logic [7:0] OHF_CMD_COLUMN = 8'h15;
  localparam logic [7:0] OHF_CMD_LOCK = 8'hfd;
  localparam logic [7:0] OHF_LCK_A = 8'ha2;
  localparam logic [7:0] OHF_LCK_B = 8'hb1;
  localparam logic [7:0] OHF_LCK_C = 8'hb3;
  localparam logic [7:0] OHF_LCK_D = 8'hbb;
  localparam logic [7:0] OHF_LCK_E = 8'hbe;
  localparam logic [7:0] OHF_LOCK_ARG_SET = 8'hb0;
  localparam logic [7:0] OHF_LOCK_ARG_CLR = 8'hb1;

  localparam logic [7:0] OHF_MUX_RST = 8'h7f;
  localparam logic [7:0] OHF_REMAP_RST = 8'h00;
  localparam logic [6:0] OHF_START_RST = 7'h00;
  localparam logic [6:0] OHF_COL_RST = 7'h00;
  localparam logic OHF_LOCK_RST = 1'b1;
  localparam int OHF_ST_DISP_BIT = 7;
  localparam int OHF_ST_LOCK_BIT = 6;

  localparam int OHF_SYS_CLK_NS = 25;
  localparam int OHF_SCLK_HALF_NS = 50;
  localparam int OHF_SCLK_HALF_CYC = (OHF_SCLK_HALF_NS + OHF_SYS_CLK_NS - 1) / OHF_SYS_CLK_NS;
  localparam int OHF_STROBE_CYC = 8;
  localparam int OHF_HOLD_CYC = 4;
  localparam int OHF_PWR_SETTLE_MS = 100;
  localparam int OHF_SYS_CLK_KHZ = 40000;
  localparam int OHF_PWR_SETTLE_CYC = OHF_PWR_SETTLE_MS * OHF_SYS_CLK_KHZ;

  function automatic ohf_mode_t ohf_mode_decode(input logic a, input logic b);
    if (!a && !b) begin
      return OHF_MODE_SERIAL;
    end else if (a && b) begin
      return OHF_MODE_ESTROBE;
    end else if (!a && b) begin
      return OHF_MODE_SSTROBE;
    end
    return OHF_MODE_NONE;
  endfunction

  function automatic logic [1:0] ohf_mode_straps(input ohf_mode_t m);
    case (m)
      OHF_MODE_ESTROBE: return 2'h3;
      OHF_MODE_SSTROBE: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

endpackage

// [rtl/ohf_device.sv]
// Display controller front end: host mode select, serial and parallel
// byte capture, command decode and display state. Assumes link_clk is the
// serial clock (bus bit 0) made by the host, unrelated to sys_clk.
`timescale 1ns/1ps
module ohf_device (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic link_clk,
  ohf_if.dev pins,
  output logic display_on,
  output logic [7:0] mux_ratio,
  output logic [7:0] remap,
  output logic [6:0] start_line,
  output logic [6:0] col_addr,
  output logic cmds_locked,
  output ohf_pkg::ohf_mode_t host_mode,
  output logic data_valid,
  output logic [7:0] data_byte,
  output logic [6:0] data_col
);

  typedef enum logic [1:0] {OHF_ST_IDLE, OHF_ST_ARG, OHF_ST_ARG2} ohf_dst_t;

  function automatic logic ohf_is_locked_cmd(input logic [7:0] c);
    return (c == ohf_pkg::OHF_LCK_A) || (c == ohf_pkg::OHF_LCK_B) ||
      (c == ohf_pkg::OHF_LCK_C) || (c == ohf_pkg::OHF_LCK_D) || (c == ohf_pkg::OHF_LCK_E);
  endfunction

  function automatic logic ohf_has_arg(input logic [7:0] c);
    return (c == ohf_pkg::OHF_CMD_REMAP) || (c == ohf_pkg::OHF_CMD_START) ||
      (c == ohf_pkg::OHF_CMD_MUX) || (c == ohf_pkg::OHF_CMD_COLUMN) ||
      (c == ohf_pkg::OHF_CMD_LOCK);
  endfunction

  // Link domain: serial shifter, reset while deselected
  logic lrst_n;
  logic [6:0] ser_shift_q;
  logic [2:0] ser_cnt_q;
  logic [7:0] ser_byte_q;
  logic ser_dc_q;
  logic ser_tgl_q;

  // Deselect clears a partial byte; the clock may stop between frames
  assign lrst_n = rstn & ~pins.cs_n & pins.hard_reset_n;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ser_shift_q <= 7'h00;
      ser_cnt_q <= 3'h0;
    end else begin
      ser_shift_q <= {ser_shift_q[5:0], pins.host_data_bus[1]};
      ser_cnt_q <= ser_cnt_q + 3'h1;
    end
  end

  // Byte and toggle survive deselect so the last byte still crosses
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      ser_byte_q <= 8'h00;
      ser_dc_q <= 1'b0;
      ser_tgl_q <= 1'b0;
    end else if (!pins.cs_n && ser_cnt_q == 3'h7) begin
      ser_byte_q <= {ser_shift_q, pins.host_data_bus[1]};
      ser_dc_q <= pins.dc;
      ser_tgl_q <= ~ser_tgl_q;
    end
  end

  // System domain: pin and toggle synchronisers
  ohf_pkg::ohf_pins_t pin_raw;
  ohf_pkg::ohf_pins_t pin_s1_q;
  ohf_pkg::ohf_pins_t pin_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;

  assign pin_raw = '{hard_reset_n: pins.hard_reset_n, strap_b: pins.strap_b,
    strap_a: pins.strap_a, dc: pins.dc, rw_wr: pins.rw_wr, e_rd: pins.e_rd,
    cs_n: pins.cs_n, bus: pins.host_data_bus};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_q <= '0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else if (clk_en) begin
      pin_s1_q <= pin_raw;
      pin_q <= pin_s1_q;
      tgl_s1_q <= ser_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  ohf_pkg::ohf_mode_t mode;
  logic hard_rst;
  logic ser_evt;
  logic wr_act;
  logic rd_act;
  logic ser_mode;

  assign mode = ohf_pkg::ohf_mode_decode(pin_q.strap_a, pin_q.strap_b);
  assign hard_rst = ~pin_q.hard_reset_n;
  assign ser_evt = tgl_s2_q ^ tgl_s3_q;
  assign ser_mode = (mode == ohf_pkg::OHF_MODE_SERIAL);

  always_comb begin
    wr_act = 1'b0;
    rd_act = 1'b0;
    case (mode)
      ohf_pkg::OHF_MODE_ESTROBE: begin
        wr_act = pin_q.e_rd & ~pin_q.rw_wr;
        rd_act = pin_q.e_rd & pin_q.rw_wr;
      end
      ohf_pkg::OHF_MODE_SSTROBE: begin
        wr_act = ~pin_q.rw_wr;
        rd_act = ~pin_q.e_rd;
      end
      default: begin
        wr_act = 1'b0;
        rd_act = 1'b0;
      end
    endcase
    wr_act = wr_act & ~pin_q.cs_n;
    rd_act = rd_act & ~pin_q.cs_n;
  end

  // Parallel write: latch while strobe active, commit when it ends
  logic wr_act_q;
  logic [7:0] par_byte_q;
  logic par_dc_q;
  logic byte_evt;
  logic [7:0] byte_val;
  logic byte_dc;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_act_q <= 1'b0;
      par_byte_q <= 8'h00;
      par_dc_q <= 1'b0;
    end else if (clk_en) begin
      wr_act_q <= wr_act & ~hard_rst;
      if (wr_act) begin
        par_byte_q <= pin_q.bus;
        par_dc_q <= pin_q.dc;
      end
    end
  end

  assign byte_evt = ~hard_rst & (ser_mode ? ser_evt : (wr_act_q & ~wr_act));
  assign byte_val = ser_mode ? ser_byte_q : par_byte_q;
  assign byte_dc = ser_mode ? ser_dc_q : par_dc_q;

  // Parallel read: device drives status onto the bus only while reading
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pins.dev_bus_oe <= 1'b0;
      pins.dev_bus_out <= 8'h00;
    end else if (clk_en) begin
      pins.dev_bus_oe <= rd_act & ~hard_rst;
      pins.dev_bus_out <= 8'h00;
      pins.dev_bus_out[ohf_pkg::OHF_ST_DISP_BIT] <= display_on;
      pins.dev_bus_out[ohf_pkg::OHF_ST_LOCK_BIT] <= cmds_locked;
    end
  end

  // Command decoder and display state
  ohf_dst_t st_q;
  logic [7:0] pend_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= OHF_ST_IDLE;
      pend_q <= 8'h00;
      display_on <= 1'b0;
      mux_ratio <= ohf_pkg::OHF_MUX_RST;
      remap <= ohf_pkg::OHF_REMAP_RST;
      start_line <= ohf_pkg::OHF_START_RST;
      col_addr <= ohf_pkg::OHF_COL_RST;
      cmds_locked <= ohf_pkg::OHF_LOCK_RST;
      data_valid <= 1'b0;
      data_byte <= 8'h00;
      data_col <= ohf_pkg::OHF_COL_RST;
    end else if (clk_en) begin
      data_valid <= 1'b0;
      if (hard_rst) begin
        st_q <= OHF_ST_IDLE;
        display_on <= 1'b0;
        mux_ratio <= ohf_pkg::OHF_MUX_RST;
        remap <= ohf_pkg::OHF_REMAP_RST;
        start_line <= ohf_pkg::OHF_START_RST;
        col_addr <= ohf_pkg::OHF_COL_RST;
        cmds_locked <= ohf_pkg::OHF_LOCK_RST;
      end else if (byte_evt && byte_dc) begin
        data_valid <= 1'b1;
        data_byte <= byte_val;
        data_col <= col_addr;
        col_addr <= col_addr + 7'h01;
      end else if (byte_evt) begin
        case (st_q)
          OHF_ST_IDLE: begin
            if (cmds_locked && ohf_is_locked_cmd(byte_val)) begin
              st_q <= OHF_ST_IDLE;
            end else if (byte_val == ohf_pkg::OHF_CMD_DISP_OFF) begin
              display_on <= 1'b0;
            end else if (byte_val == ohf_pkg::OHF_CMD_DISP_ON) begin
              display_on <= 1'b1;
            end else if (ohf_has_arg(byte_val)) begin
              pend_q <= byte_val;
              st_q <= OHF_ST_ARG;
            end
          end
          OHF_ST_ARG: begin
            st_q <= OHF_ST_IDLE;
            case (pend_q)
              ohf_pkg::OHF_CMD_REMAP: remap <= byte_val;
              ohf_pkg::OHF_CMD_START: start_line <= byte_val[6:0];
              ohf_pkg::OHF_CMD_MUX: mux_ratio <= byte_val;
              ohf_pkg::OHF_CMD_COLUMN: begin
                col_addr <= byte_val[6:0];
                st_q <= OHF_ST_ARG2;
              end
              ohf_pkg::OHF_CMD_LOCK: begin
                if (byte_val == ohf_pkg::OHF_LOCK_ARG_SET) begin
                  cmds_locked <= 1'b1;
                end else if (byte_val == ohf_pkg::OHF_LOCK_ARG_CLR) begin
                  cmds_locked <= 1'b0;
                end
              end
              default: st_q <= OHF_ST_IDLE;
            endcase
          end
          OHF_ST_ARG2: st_q <= OHF_ST_IDLE;
          default: st_q <= OHF_ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      host_mode <= ohf_pkg::OHF_MODE_SERIAL;
    end else if (clk_en) begin
      host_mode <= mode;
    end
  end

endmodule

// [rtl/ohf_host.sv]
// Host side: byte transfers in the strapped mode, hard reset and the panel
// supply power sequence. Assumes the device answers reads within the strobe.
`timescale 1ns/1ps
module ohf_host #(
  parameter int unsigned SETTLE_CYCLES = ohf_pkg::OHF_PWR_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  ohf_if.host pins,
  input ohf_pkg::ohf_mode_t mode_sel,
  input wire logic hard_reset_req,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic req_dc,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic pwr_up_req,
  input wire logic pwr_down_req,
  input wire logic init_done,
  output logic logic_supply_en,
  output logic panel_supply_en,
  output logic pwr_busy
);

  typedef enum logic [2:0] {
    OHF_X_IDLE, OHF_X_SETUP, OHF_X_STROBE, OHF_X_HOLD, OHF_X_SHIFT
  } ohf_xst_t;
  typedef enum logic [2:0] {
    OHF_P_OFF, OHF_P_UP_OFF, OHF_P_INIT, OHF_P_SETTLE, OHF_P_UP_ON, OHF_P_ON,
    OHF_P_DN_OFF, OHF_P_DISCH
  } ohf_pst_t;

  ohf_xst_t xs_q;
  ohf_pst_t ps_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic [3:0] cnt_q;
  logic [2:0] bit_q;
  logic [31:0] wait_q;
  logic [7:0] bus_s1_q;
  logic [7:0] bus_s2_q;
  logic pwr_send;
  logic [7:0] pwr_cmd;
  logic go;

  // Power sequencer injects display on/off commands ahead of the user
  assign pwr_send = (ps_q == OHF_P_UP_OFF) || (ps_q == OHF_P_UP_ON) || (ps_q == OHF_P_DN_OFF);
  assign pwr_cmd = (ps_q == OHF_P_UP_ON) ? ohf_pkg::OHF_CMD_DISP_ON : ohf_pkg::OHF_CMD_DISP_OFF;
  assign go = (xs_q == OHF_X_IDLE) && (pwr_send || req_valid);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ps_q <= OHF_P_OFF;
      wait_q <= 32'h0;
      logic_supply_en <= 1'b0;
      panel_supply_en <= 1'b0;
      pwr_busy <= 1'b0;
    end else if (clk_en) begin
      pwr_busy <= (ps_q != OHF_P_OFF) && (ps_q != OHF_P_ON);
      case (ps_q)
        OHF_P_OFF: if (pwr_up_req) begin
          logic_supply_en <= 1'b1;
          ps_q <= OHF_P_UP_OFF;
        end
        OHF_P_UP_OFF: if (go) ps_q <= OHF_P_INIT;
        OHF_P_INIT: if (init_done) begin
          panel_supply_en <= 1'b1;
          wait_q <= 32'h0;
          ps_q <= OHF_P_SETTLE;
        end
        OHF_P_SETTLE: begin
          wait_q <= wait_q + 32'h1;
          if (wait_q == SETTLE_CYCLES - 1) ps_q <= OHF_P_UP_ON;
        end
        OHF_P_UP_ON: if (go) ps_q <= OHF_P_ON;
        OHF_P_ON: if (pwr_down_req) ps_q <= OHF_P_DN_OFF;
        OHF_P_DN_OFF: if (go && xs_q == OHF_X_IDLE) begin
          panel_supply_en <= 1'b0;
          wait_q <= 32'h0;
          ps_q <= OHF_P_DISCH;
        end
        OHF_P_DISCH: begin
          wait_q <= wait_q + 32'h1;
          if (wait_q == SETTLE_CYCLES - 1) begin
            logic_supply_en <= 1'b0;
            ps_q <= OHF_P_OFF;
          end
        end
        default: ps_q <= OHF_P_OFF;
      endcase
    end
  end

  // Read data crosses from the device's drive, so it is synchronised
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
    end else if (clk_en) begin
      bus_s1_q <= pins.host_data_bus;
      bus_s2_q <= bus_s1_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pins.hard_reset_n <= 1'b0;
      pins.strap_a <= 1'b0;
      pins.strap_b <= 1'b0;
    end else if (clk_en) begin
      pins.hard_reset_n <= ~hard_reset_req;
      {pins.strap_b, pins.strap_a} <= ohf_pkg::ohf_mode_straps(mode_sel);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      xs_q <= OHF_X_IDLE;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      cnt_q <= 4'h0;
      bit_q <= 3'h0;
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      pins.cs_n <= 1'b1;
      pins.dc <= 1'b0;
      pins.e_rd <= 1'b0;
      pins.rw_wr <= 1'b0;
      pins.host_bus_out <= 8'h00;
      pins.host_bus_oe <= 8'h00;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      req_ready <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      case (xs_q)
        OHF_X_IDLE: begin
          // Serial keeps strobes low; separate strobes idle high
          pins.e_rd <= (mode_sel == ohf_pkg::OHF_MODE_SSTROBE);
          pins.rw_wr <= (mode_sel == ohf_pkg::OHF_MODE_SSTROBE);
          cnt_q <= 4'h0;
          if (go) begin
            req_ready <= ~pwr_send;
            sh_q <= pwr_send ? pwr_cmd : req_data;
            rd_q <= ~pwr_send & req_read & (mode_sel != ohf_pkg::OHF_MODE_SERIAL);
            pins.dc <= ~pwr_send & req_dc;
            pins.cs_n <= 1'b0;
            bit_q <= 3'h0;
            if (mode_sel == ohf_pkg::OHF_MODE_SERIAL) begin
              pins.host_bus_oe <= 8'h03;
              pins.host_bus_out <= {6'h00, pwr_send ? pwr_cmd[7] : req_data[7], 1'b0};
              xs_q <= OHF_X_SHIFT;
            end else begin
              pins.host_bus_out <= pwr_send ? pwr_cmd : req_data;
              pins.host_bus_oe <= (!pwr_send && req_read) ? 8'h00 : 8'hff;
              if (mode_sel == ohf_pkg::OHF_MODE_ESTROBE) begin
                pins.rw_wr <= ~pwr_send & req_read;
              end
              xs_q <= OHF_X_SETUP;
            end
          end
        end
        OHF_X_SHIFT: if (cnt_q == 4'(ohf_pkg::OHF_SCLK_HALF_CYC - 1)) begin
          cnt_q <= 4'h0;
          if (!pins.host_bus_out[0]) begin
            pins.host_bus_out[0] <= 1'b1;
          end else begin
            pins.host_bus_out[0] <= 1'b0;
            bit_q <= bit_q + 3'h1;
            sh_q <= {sh_q[6:0], 1'b0};
            pins.host_bus_out[1] <= sh_q[6];
            if (bit_q == 3'h7) xs_q <= OHF_X_HOLD;
          end
        end
        OHF_X_SETUP: begin
          cnt_q <= 4'h0;
          xs_q <= OHF_X_STROBE;
          if (mode_sel == ohf_pkg::OHF_MODE_ESTROBE) pins.e_rd <= 1'b1;
          else if (rd_q) pins.e_rd <= 1'b0;
          else pins.rw_wr <= 1'b0;
        end
        OHF_X_STROBE: if (cnt_q == 4'(ohf_pkg::OHF_STROBE_CYC - 1)) begin
          cnt_q <= 4'h0;
          pins.e_rd <= (mode_sel == ohf_pkg::OHF_MODE_SSTROBE);
          if (mode_sel == ohf_pkg::OHF_MODE_SSTROBE) pins.rw_wr <= 1'b1;
          rd_valid <= rd_q;
          if (rd_q) rd_data <= bus_s2_q;
          xs_q <= OHF_X_HOLD;
        end
        OHF_X_HOLD: if (cnt_q == 4'(ohf_pkg::OHF_HOLD_CYC - 1)) begin
          pins.cs_n <= 1'b1;
          pins.host_bus_oe <= 8'h00;
          pins.host_bus_out <= 8'h00;
          pins.rw_wr <= (mode_sel == ohf_pkg::OHF_MODE_SSTROBE);
          xs_q <= OHF_X_IDLE;
        end
        default: xs_q <= OHF_X_IDLE;
      endcase
    end
  end

endmodule

// [verif/ohf_checker.sv]
// Pin checks on the host/display link, both ends being design code.
// Assumes both ends run on sys_clk and share the rstn reset.
`timescale 1ns/1ps
module ohf_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic strap_a,
  input wire logic strap_b,
  input wire logic e_rd,
  input wire logic rw_wr,
  input wire logic [7:0] host_bus_out,
  input wire logic [7:0] host_bus_oe,
  input wire logic [7:0] dev_bus_out,
  input wire logic dev_bus_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_cs_idle;
    cs_n [*8] |-> !dev_bus_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("device drives bus while deselected");
  property p_ser_quiet;
    (!strap_a && !strap_b) [*4] |-> !dev_bus_oe;
  endproperty
  a_ser_quiet: assert property (p_ser_quiet)
    else $error("device drives bus in serial mode");
  property p_ss_read;
    $rose(dev_bus_oe) && !strap_a && strap_b |-> !$past(e_rd, 3) && !$past(cs_n, 3);
  endproperty
  a_ss_read: assert property (p_ss_read)
    else $error("read drive without read strobe");
  property p_es_read;
    $rose(dev_bus_oe) && strap_a && strap_b
      |-> $past(e_rd, 3) && $past(rw_wr, 3) && !$past(cs_n, 3);
  endproperty
  a_es_read: assert property (p_es_read)
    else $error("read drive without enable and read direction");
  // Data must settle half a clock before the rising sample
  property p_ser_shift;
    !cs_n && !$past(cs_n) && !strap_a && !strap_b && $changed(host_bus_out[1])
      |-> $fell(host_bus_out[0]);
  endproperty
  a_ser_shift: assert property (p_ser_shift)
    else $error("serial data moved off the falling clock");
  property p_ser_strobes;
    !strap_a && !strap_b && !cs_n |-> !e_rd && !rw_wr;
  endproperty
  a_ser_strobes: assert property (p_ser_strobes)
    else $error("strobes not low in serial mode");
  property p_ss_wr;
    $fell(rw_wr) && !cs_n && !strap_a && strap_b |-> (!rw_wr && !cs_n) [*8] ##1 rw_wr;
  endproperty
  a_ss_wr: assert property (p_ss_wr)
    else $error("write strobe width wrong");
  property p_es_enable;
    $rose(e_rd) && !cs_n && strap_a && strap_b |-> (e_rd && !cs_n) [*8] ##1 !e_rd;
  endproperty
  a_es_enable: assert property (p_es_enable)
    else $error("enable pulse wrong");
  property p_no_fight;
    dev_bus_oe |-> host_bus_oe == 8'h00 && dev_bus_out[5:0] == 6'h00;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bus contention or bad status byte");
endmodule

// [verif/tb_top.sv]
// Bench joining the host end and the display end over the pin interface.
// Assumes one sys_clk for both ends; the host makes the serial clock.
`timescale 1ns/1ps
module tb_top;
  localparam int SETTLE = 20;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hard_reset_req = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_dc = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic pwr_up_req = 1'b0;
  logic pwr_down_req = 1'b0;
  logic init_done = 1'b0;
  ohf_pkg::ohf_mode_t mode_sel = ohf_pkg::OHF_MODE_SERIAL;
  ohf_pkg::ohf_mode_t host_mode;
  logic req_ready, rd_valid, logic_supply_en, panel_supply_en, pwr_busy;
  logic display_on, cmds_locked, data_valid;
  logic [7:0] rd_data, mux_ratio, remap, data_byte, got_byte, got_rd;
  logic [6:0] start_line, col_addr, data_col, got_col;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int gap_up = 0;
  int gap_dn = 0;
  always #12.5 sys_clk = ~sys_clk;
  ohf_if i_ohf_if ();
  ohf_device i_ohf_device (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .link_clk(i_ohf_if.host_data_bus[0]),
    .pins(i_ohf_if.dev), .display_on(display_on), .mux_ratio(mux_ratio), .remap(remap),
    .start_line(start_line), .col_addr(col_addr), .cmds_locked(cmds_locked),
    .host_mode(host_mode), .data_valid(data_valid), .data_byte(data_byte), .data_col(data_col)
  );
  ohf_host #(.SETTLE_CYCLES(SETTLE)) i_ohf_host (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .pins(i_ohf_if.host), .mode_sel(mode_sel),
    .hard_reset_req(hard_reset_req), .req_valid(req_valid), .req_read(req_read),
    .req_dc(req_dc), .req_data(req_data), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .pwr_up_req(pwr_up_req), .pwr_down_req(pwr_down_req),
    .init_done(init_done), .logic_supply_en(logic_supply_en),
    .panel_supply_en(panel_supply_en), .pwr_busy(pwr_busy)
  );
  ohf_checker i_ohf_checker (
    .sys_clk(sys_clk), .rstn(rstn), .cs_n(i_ohf_if.cs_n), .strap_a(i_ohf_if.strap_a),
    .strap_b(i_ohf_if.strap_b), .e_rd(i_ohf_if.e_rd), .rw_wr(i_ohf_if.rw_wr),
    .host_bus_out(i_ohf_if.host_bus_out), .host_bus_oe(i_ohf_if.host_bus_oe),
    .dev_bus_out(i_ohf_if.dev_bus_out), .dev_bus_oe(i_ohf_if.dev_bus_oe)
  );
  function automatic logic [7:0] status(input logic on, input logic lk);
    return {on, lk, 6'h00};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Monitors: captured values and power gaps
  always @(posedge sys_clk) begin
    cycles++;
    if (data_valid === 1'b1) got_byte = data_byte;
    if (data_valid === 1'b1) got_col = data_col;
    if (rd_valid === 1'b1) got_rd = rd_data;
    if (panel_supply_en === 1'b1 && display_on !== 1'b1) gap_up++;
    if (logic_supply_en === 1'b1 && panel_supply_en !== 1'b1 && pwr_busy === 1'b1) gap_dn++;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  // Request held until taken; 50 idle cycles cover a serial byte plus commit
  task automatic send(input logic rd, input logic dc, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_dc <= dc;
    req_data <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 300);
    req_valid <= 1'b0;
    chk("req_ready", 8'h01, 8'(req_ready));
    repeat (50) @(posedge sys_clk);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    // Busy rises only two edges after the request; the last command trails it
    repeat (4) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      k++;
    end while (pwr_busy !== 1'b0 && k < 900);
    repeat (60) @(posedge sys_clk);
  endtask
  task automatic check_reset();
    chk("display_on", 8'h00, 8'(display_on));
    chk("mux_ratio", 8'h7f, mux_ratio);
    chk("remap", 8'h00, remap);
    chk("start_line", 8'h00, 8'(start_line));
    chk("col_addr", 8'h00, 8'(col_addr));
    chk("cmds_locked", 8'h01, 8'(cmds_locked));
  endtask
  initial begin
    logic [7:0] v;
    logic [6:0] c;
    void'($urandom(32'hce61));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check_reset();
    for (int m = 0; m < 3; m++) begin
      mode_sel <= ohf_pkg::ohf_mode_t'(m);
      repeat (8) @(posedge sys_clk);
      chk("host_mode", 8'(m), 8'(host_mode));
      for (int i = 0; i < 2; i++) begin
        // Top of the range first, since the column must wrap there
        v = (i == 0) ? 8'h7f : 8'($urandom()) & 8'h7f;
        c = (i == 0) ? 7'h7f : 7'($urandom());
        send(1'b0, 1'b0, ohf_pkg::OHF_CMD_START);
        send(1'b0, 1'b0, v);
        chk("start_line", v, 8'(start_line));
        send(1'b0, 1'b0, ohf_pkg::OHF_CMD_MUX);
        send(1'b0, 1'b0, v);
        chk("mux_ratio", v, mux_ratio);
        send(1'b0, 1'b0, ohf_pkg::OHF_CMD_REMAP);
        send(1'b0, 1'b0, ~v);
        chk("remap", ~v, remap);
        send(1'b0, 1'b0, ohf_pkg::OHF_CMD_COLUMN);
        send(1'b0, 1'b0, {1'b0, c});
        send(1'b0, 1'b0, 8'h7f);
        v = 8'($urandom());
        send(1'b0, 1'b1, v);
        chk("data_byte", v, got_byte);
        chk("data_col", {1'b0, c}, {1'b0, got_col});
        send(1'b0, 1'b1, ~v);
        chk("data_col", {1'b0, c + 7'h01}, {1'b0, got_col});
        send(1'b0, 1'b0, ohf_pkg::OHF_CMD_LOCK);
        send(1'b0, 1'b0, i ? ohf_pkg::OHF_LOCK_ARG_SET : ohf_pkg::OHF_LOCK_ARG_CLR);
        send(1'b0, 1'b0, i ? ohf_pkg::OHF_CMD_DISP_OFF : ohf_pkg::OHF_CMD_DISP_ON);
        chk("cmds_locked", 8'(i), 8'(cmds_locked));
        chk("display_on", 8'(1 - i), 8'(display_on));
        // A command code sent as data must not act
        send(1'b0, 1'b1, ohf_pkg::OHF_CMD_DISP_ON);
        chk("display_on", 8'(1 - i), 8'(display_on));
        if (m != 0) begin
          send(1'b1, 1'b0, 8'h00);
          chk("rd_data", status(i == 0, i == 1), got_rd);
        end
      end
    end
    mode_sel <= ohf_pkg::OHF_MODE_SERIAL;
    repeat (8) @(posedge sys_clk);
    send(1'b0, 1'b0, ohf_pkg::OHF_CMD_DISP_ON);
    // Unlock first so the reset's relock is visible
    send(1'b0, 1'b0, ohf_pkg::OHF_CMD_LOCK);
    send(1'b0, 1'b0, ohf_pkg::OHF_LOCK_ARG_CLR);
    // Commands keep data/command low, as a 3-wire host ties it
    send(1'b0, 1'b0, ohf_pkg::OHF_CMD_START);
    send(1'b0, 1'b0, 8'h2a);
    hard_reset_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    hard_reset_req <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check_reset();
    pwr_up_req <= 1'b1;
    @(posedge sys_clk);
    pwr_up_req <= 1'b0;
    repeat (80) @(posedge sys_clk);
    chk("logic_supply_en", 8'h01, 8'(logic_supply_en));
    chk("panel_supply_en", 8'h00, 8'(panel_supply_en));
    init_done <= 1'b1;
    wait_idle();
    init_done <= 1'b0;
    chk("panel_supply_en", 8'h01, 8'(panel_supply_en));
    chk("display_on", 8'h01, 8'(display_on));
    chk("settle_up", 8'h01, 8'(gap_up >= SETTLE));
    gap_dn = 0;
    pwr_down_req <= 1'b1;
    @(posedge sys_clk);
    pwr_down_req <= 1'b0;
    wait_idle();
    chk("display_on", 8'h00, 8'(display_on));
    chk("supplies", 8'h00, {6'h00, logic_supply_en, panel_supply_en});
    chk("settle_down", 8'h01, 8'(gap_dn >= SETTLE));
    close_out();
  end
endmodule
